// ---- include/tcpwm_pkg.sv ----
// Package with register map, field layout and counts for the three-channel modulator.
`default_nettype none
package tcpwm_pkg;
   localparam int TCPWM_CHANNELS = 3;
   localparam int TCPWM_ADDR_W = 4;
   localparam logic [3:0] TCPWM_OFS_DUTY0 = 4'h0;
   localparam logic [3:0] TCPWM_OFS_DUTY1 = 4'h4;
   localparam logic [3:0] TCPWM_OFS_DUTY2 = 4'h8;
   localparam logic [3:0] TCPWM_OFS_PORT = 4'hc;
   localparam logic [7:0] TCPWM_DUTY_RESET = 8'h00;
   localparam logic [2:0] TCPWM_DIR_RESET = 3'h7;
   localparam logic [2:0] TCPWM_LATCH_RESET = 3'h0;
   localparam int TCPWM_PORT_DIR_LSB = 0;
   localparam int TCPWM_PORT_LATCH_LSB = 4;
   localparam int TCPWM_PORT_MODE_BIT = 8;
   localparam int TCPWM_PORT_PIN_LSB = 12;
   localparam int TCPWM_CYCLE_CLOCKS = 256;
   localparam int TCPWM_SUB4_CLOCKS = 64;
   localparam int TCPWM_SUB2_CLOCKS = 128;
   localparam logic [1:0] TCPWM_RESP_OKAY = 2'h0;
   localparam logic [1:0] TCPWM_RESP_SLVERR = 2'h2;
   typedef enum logic {
      TCPWM_MODE_FOUR = 1'b0,
      TCPWM_MODE_TWO = 1'b1
   } tcpwm_mode_e;
endpackage
`default_nettype wire

// ---- rtl/tcpwm_channel.sv ----
// One modulator channel: latched duty and comparison against the shared counter.
`default_nettype none
module tcpwm_channel
   import tcpwm_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Shared timing
   input wire logic [7:0] cycle_count,
   input wire logic mode_two,
   // Duty value from software
   input wire logic [7:0] duty_value,
   // Waveform
   output logic wave
);
   logic [7:0] duty_live_reg;
   logic [7:0] duty_live_next;
   logic [6:0] coarse_duty_bits;
   logic [1:0] fine_step_bits;
   logic [6:0] phase;
   logic [1:0] sub_index;
   logic extra;
   logic [7:0] high_len;

   // A new value is taken only at a cycle boundary.
   assign duty_live_next = (cycle_count == 8'hff) ? duty_value : duty_live_reg;
   assign coarse_duty_bits = mode_two ? duty_live_reg[7:1] : {1'b0, duty_live_reg[7:2]};
   assign fine_step_bits = mode_two ? {1'b0, duty_live_reg[0]} : duty_live_reg[1:0];
   assign sub_index = mode_two ? {1'b0, cycle_count[7]} : cycle_count[7:6];
   assign phase = mode_two ? cycle_count[6:0] : {1'b0, cycle_count[5:0]};
   assign extra = sub_index < fine_step_bits;
   assign high_len = {1'b0, coarse_duty_bits} + {7'h00, extra};
   assign wave = {1'b0, phase} < high_len;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         duty_live_reg <= TCPWM_DUTY_RESET;
      end else begin
         duty_live_reg <= duty_live_next;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/tcpwm_top.sv ----
// Three-channel modulator with port pin sharing and an AXI4-Lite register slave.
// Notes on behaviour
// - Three independent outputs, each set by its own 8-bit duty register.
// - A channel not selected at build time leaves its pin an ordinary port pin.
// - A build-time option picks the four-sub-cycle or the two-sub-cycle scheme.
// - The counter advances every clock and a full cycle spans 256 clocks.
// - The full cycle repeats at the clock rate divided by 256.
// - Software only writes the duty value; hardware splits the cycle by itself.
// - The four-sub-cycle scheme has sub-cycles 0 to 3 of 64 clocks each.
// - The four-sub-cycle scheme takes coarse duty from bits 7:2 and fine steps from 1:0.
// - A four-scheme sub-cycle is high coarse plus one clocks below the fine count, else coarse.
// - The two-sub-cycle scheme has sub-cycles 0 and 1 of 128 clocks each.
// - The two-sub-cycle scheme takes coarse duty from bits 7:1 and the fine bit from bit 0.
// - A two-scheme sub-cycle is high coarse plus one clocks below the fine bit, else coarse.
// - With the latch bit at one the pin shows the waveform; at zero it is held low.
// - With the direction bit at one the pin is an ordinary input with its pull-high.
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`default_nettype none
module tcpwm_top
   import tcpwm_pkg::*;
#(
   parameter logic [2:0] CHANNEL_ENABLE = 3'h7,
   parameter logic MODE_TWO = 1'b0
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address channel
   input wire logic [TCPWM_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // Write data channel
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // Write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read address channel
   input wire logic [TCPWM_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // Read data channel
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Shared pins, bit n for channel n
   input wire logic [2:0] pin_in,
   output logic [2:0] pin_out,
   output logic [2:0] pin_oe,
   output logic [2:0] pin_pullup
);
   logic [7:0] cycle_count_reg;
   logic [7:0] cycle_count_next;
   logic [7:0] duty_reg [TCPWM_CHANNELS];
   logic [2:0] dir_reg;
   logic [2:0] latch_reg;
   logic [2:0] wave;
   logic [2:0] pin_out_next;
   logic [2:0] pin_oe_next;
   logic aw_hold_reg;
   logic w_hold_reg;
   logic [3:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic aw_take;
   logic w_take;
   logic wr_fire;
   logic ar_take;
   logic [3:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_hit;
   logic rd_hit;
   logic [31:0] port_word;
   logic [31:0] rd_word;

   // Free-running cycle counter.
   assign cycle_count_next = cycle_count_reg + 8'h01;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cycle_count_reg <= 8'h00;
      end else begin
         cycle_count_reg <= cycle_count_next;
      end
   end

   // Per-channel modulators and pin muxing.
   genvar g;
   generate
      for (g = 0; g < TCPWM_CHANNELS; g++) begin : gen_ch
         tcpwm_channel u_ch (
            .aclk(aclk),
            .aresetn(aresetn),
            .cycle_count(cycle_count_reg),
            .mode_two(MODE_TWO),
            .duty_value(duty_reg[g]),
            .wave(wave[g])
         );
         // The pin drives when the direction bit is zero, otherwise it is an input.
         assign pin_oe_next[g] = !dir_reg[g];
         // Modulator wins only if built in; latch then gates it, else plain port data.
         assign pin_out_next[g] = CHANNEL_ENABLE[g] ?
            (latch_reg[g] & wave[g]) : latch_reg[g];
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out <= 3'h0;
         pin_oe <= 3'h0;
         pin_pullup <= 3'h0;
      end else begin
         pin_out <= pin_out_next;
         pin_oe <= pin_oe_next;
         pin_pullup <= dir_reg;
      end
   end

   // Write path: address and data may arrive in either order.
   assign aw_take = s_axi_awvalid & s_axi_awready;
   assign w_take = s_axi_wvalid & s_axi_wready;
   assign wr_addr = aw_hold_reg ? aw_addr_reg : s_axi_awaddr;
   assign wr_data = w_hold_reg ? w_data_reg : s_axi_wdata;
   assign wr_strb = w_hold_reg ? w_strb_reg : s_axi_wstrb;
   assign wr_fire = (aw_hold_reg | aw_take) & (w_hold_reg | w_take) & !bvalid_reg;
   assign wr_hit = (wr_addr[1:0] == 2'h0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_addr_reg <= 4'h0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_addr_reg <= s_axi_awaddr;
         end
         if (w_take) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         aw_hold_reg <= (aw_hold_reg | aw_take) & !wr_fire;
         w_hold_reg <= (w_hold_reg | w_take) & !wr_fire;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_hold_reg & !aw_take & !bvalid_reg & !wr_fire;
         s_axi_wready <= !w_hold_reg & !w_take & !bvalid_reg & !wr_fire;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= TCPWM_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_hit ? TCPWM_RESP_OKAY : TCPWM_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // Register writes.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < TCPWM_CHANNELS; i++) begin
            duty_reg[i] <= TCPWM_DUTY_RESET;
         end
         dir_reg <= TCPWM_DIR_RESET;
         latch_reg <= TCPWM_LATCH_RESET;
      end else if (wr_fire) begin
         for (int i = 0; i < TCPWM_CHANNELS; i++) begin
            if (wr_addr == 4'(4 * i) && wr_strb[0]) begin
               duty_reg[i] <= wr_data[7:0];
            end
         end
         if (wr_addr == TCPWM_OFS_PORT && wr_strb[0]) begin
            dir_reg <= wr_data[TCPWM_PORT_DIR_LSB +: 3];
            latch_reg <= wr_data[TCPWM_PORT_LATCH_LSB +: 3];
         end
      end
   end

   // Read path.
   assign ar_take = s_axi_arvalid & s_axi_arready;
   assign rd_hit = (s_axi_araddr[1:0] == 2'h0);
   assign port_word = {17'h00000, pin_in, 3'h0, 1'(MODE_TWO), 1'b0, latch_reg, 1'b0, dir_reg};
   assign rd_word = (s_axi_araddr == TCPWM_OFS_DUTY0) ? {24'h000000, duty_reg[0]} :
                    (s_axi_araddr == TCPWM_OFS_DUTY1) ? {24'h000000, duty_reg[1]} :
                    (s_axi_araddr == TCPWM_OFS_DUTY2) ? {24'h000000, duty_reg[2]} :
                    (s_axi_araddr == TCPWM_OFS_PORT) ? port_word : 32'h00000000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= TCPWM_RESP_OKAY;
      end else begin
         s_axi_arready <= !rvalid_reg & !ar_take;
         if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_hit ? TCPWM_RESP_OKAY : TCPWM_RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
endmodule
`default_nettype wire

// ---- verification/tcpwm_load.sv ----
// Simple load model that resolves the level on each shared pin.
`default_nettype none
module tcpwm_load (
   // Clock
   input wire logic aclk,
   // Pin drive from the modulator
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe,
   input wire logic [2:0] pin_pullup,
   // Resolved pin level
   output logic [2:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] last_reg;
   always_ff @(posedge aclk) begin
      last_reg <= pin_in;
   end
   // A released pin without pull-high shows the inverse of its last level.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_pullup) | (~pin_oe & ~pin_pullup & ~last_reg);
endmodule
`default_nettype wire

// ---- verification/tcpwm_assertions.sv ----
// Checker of register bus handshakes and pin direction of the modulator.
`default_nettype none
module tcpwm_assertions (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins
   input wire logic [2:0] pin_oe,
   input wire logic [2:0] pin_pullup
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_b_lat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
   endproperty
   a_b_lat: assert property (p_b_lat) else $error("write response late");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_b_done;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_done: assert property (p_b_done) else $error("write response repeated");
   property p_w_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_w_block: assert property (p_w_block) else $error("write taken while pending");
   property p_r_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_lat: assert property (p_r_lat) else $error("read data late");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_r_block;
      s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:15] == 17'h0;
   endproperty
   a_r_block: assert property (p_r_block) else $error("read taken or wide data");
   property p_pin_dir;
      (pin_oe & pin_pullup) == 3'h0;
   endproperty
   a_pin_dir: assert property (p_pin_dir) else $error("pull-high on driven pin");
endmodule
bind tcpwm_top tcpwm_assertions u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .pin_oe(pin_oe), .pin_pullup(pin_pullup));
`default_nettype wire

// ---- verification/tcpwm_top_tb.sv ----
// Self-checking bench for the three-channel modulator.
`default_nettype none
module tcpwm_top_tb import tcpwm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [TCPWM_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, rdata2, rdat, rd2;
   logic [2:0] pin_in, pin_out, pin_oe, pin_pullup, pin_in2, pin_out2, oe2, pu2;
   wire logic [5:0] pins = {pin_out2, pin_out};
   int error_cnt = 0, checked = 0, sum, per, mx;
   int hc[6];
   int e1[6] = '{5, 129, 0, 256, 129, 0};
   always #2 aclk = ~aclk;
   tcpwm_top dut (.*);
   tcpwm_top #(.CHANNEL_ENABLE(3'h6), .MODE_TWO(1'h1)) dut2 (.*, .s_axi_awready(),
      .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_arready(), .s_axi_rdata(rdata2),
      .s_axi_rresp(), .s_axi_rvalid(), .pin_in(pin_in2), .pin_out(pin_out2), .pin_oe(oe2),
      .pin_pullup(pu2));
   tcpwm_load ld (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
      .pin_in(pin_in));
   tcpwm_load ld2 (.aclk(aclk), .pin_out(pin_out2), .pin_oe(oe2), .pin_pullup(pu2),
      .pin_in(pin_in2));
   task automatic summarize;
      if (error_cnt == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [TCPWM_ADDR_W-1:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'h1;
      w = 1'h1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (aw || w) begin
         @(posedge aclk);
         if (aw && s_axi_awready) begin
            aw = 1'h0;
            s_axi_awvalid <= 1'h0;
         end
         if (w && s_axi_wready) begin
            w = 1'h0;
            s_axi_wvalid <= 1'h0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [TCPWM_ADDR_W-1:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
      rdat = s_axi_rdata;
      rd2 = rdata2;
      resp = s_axi_rresp;
      s_axi_rready <= 1'h0;
      @(posedge aclk);
   endtask
   task automatic hi256;
      foreach (hc[k]) hc[k] = 0;
      repeat (256) begin
         @(posedge aclk);
         foreach (hc[k]) hc[k] += int'(pins[k] === 1'h1);
      end
   endtask
   task automatic runs(input int p, input int n);
      int t;
      sum = 0;
      mx = 0;
      while (pins[p] !== 1'h0) @(posedge aclk);
      while (pins[p] !== 1'h1) @(posedge aclk);
      repeat (n) begin
         t = 0;
         while (pins[p] === 1'h1) begin
            t++;
            @(posedge aclk);
         end
         sum += t;
         mx = (t > mx) ? t : mx;
         per = t;
         while (pins[p] === 1'h0) begin
            per++;
            @(posedge aclk);
         end
      end
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rd(TCPWM_OFS_PORT);
      chk(rdat, 32'h7007, "port reset");
      chk(32'(rd2[8]), 32'h1, "scheme bit");
      rd(TCPWM_OFS_DUTY1);
      chk(rdat, 32'h0, "duty reset");
      rd(4'h2);
      chk({30'h0, resp}, 32'(TCPWM_RESP_SLVERR), "unmapped read");
      wr(4'h6, 32'h1);
      chk({30'h0, resp}, 32'(TCPWM_RESP_SLVERR), "unmapped write");
      wr(TCPWM_OFS_DUTY0, 32'h5);
      wr(TCPWM_OFS_DUTY1, 32'h81);
      wr(TCPWM_OFS_DUTY2, 32'h0);
      wr(TCPWM_OFS_PORT, 32'h70);
      chk({30'h0, resp}, 32'(TCPWM_RESP_OKAY), "write resp");
      rd(TCPWM_OFS_DUTY1);
      chk(rdat, 32'h81, "duty readback");
      s_axi_wstrb <= 4'he;
      wr(TCPWM_OFS_DUTY1, 32'h33);
      s_axi_wstrb <= 4'hf;
      chk({30'h0, resp}, 32'(TCPWM_RESP_OKAY), "lane off resp");
      rd(TCPWM_OFS_DUTY1);
      chk(rdat, 32'h81, "lane off keeps");
      repeat (520) @(posedge aclk);
      hi256;
      foreach (hc[k]) chk(32'(hc[k]), 32'(e1[k]), "high count");
      chk(32'(pin_oe), 32'h7, "pin drive");
      runs(0, 4);
      chk(32'(sum), 32'h5, "four sum");
      chk(32'(mx), 32'h2, "four longest");
      chk(32'(per), 32'h40, "four period");
      runs(4, 2);
      chk(32'(sum), 32'h81, "two sum");
      chk(32'(mx), 32'h41, "two longest");
      chk(32'(per), 32'h80, "two period");
      wr(TCPWM_OFS_PORT, 32'h0);
      repeat (4) @(posedge aclk);
      hi256;
      foreach (hc[k]) chk(32'(hc[k]), 32'h0, "gated count");
      wr(TCPWM_OFS_PORT, 32'h77);
      repeat (4) @(posedge aclk);
      rd(TCPWM_OFS_PORT);
      chk(rdat, 32'h7077, "input port");
      chk({26'h0, pin_oe, pin_pullup}, 32'h7, "input pins");
      summarize;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      summarize;
   end
endmodule
`default_nettype wire
